//--- common/aifs_params.svh
// Constants for the auxiliary input function selector
`ifndef AIFS_PARAMS_SVH
`define AIFS_PARAMS_SVH
`define AIFS_SEL_RUN_CLOSED   4'h0
`define AIFS_SEL_RUN_OPEN     4'h1
`define AIFS_SEL_ALWAYS_RUN   4'h2
`define AIFS_SEL_LATCH_OPEN   4'h3
`define AIFS_SEL_REVERSAL     4'h4
`define AIFS_SEL_LATCH_CLOSED 4'h5
`define AIFS_SEL_SPEED        4'h6
`define AIFS_SEL_OVR_FWD      4'h7
`define AIFS_SEL_OVR_REV      4'h8
`define AIFS_SEL_SPECIAL      4'h9
`define AIFS_CFG_SPEC_A       4'h2
`define AIFS_CFG_SPEC_B       4'h3
`define AIFS_CFG_SPEC_C       4'h5
`define AIFS_CFG_SPEC_D       4'h6
`define AIFS_CLK_HZ           25000000
`define AIFS_REV_PAUSE_S      30
`define AIFS_DEBOUNCE_US      10000
// Avalon register byte addresses
`define AIFS_ADDR_SEL         4'h0
`define AIFS_ADDR_CFG         4'h4
`define AIFS_ADDR_HOLD        4'h8
`define AIFS_ADDR_STATUS      4'hC
`define AIFS_SEL_RESET_THREE  4'h2
`define AIFS_SEL_RESET_FOUR   4'h2
`endif

//--- common/aifs_pkg.sv
// Types for the auxiliary input function selector
package aifs_pkg;
  typedef enum logic [2:0] {
    AIFS_IDLE  = 3'b001,
    AIFS_PAUSE = 3'b010,
    AIFS_HOLD  = 3'b100
  } aifs_rev_e;
  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       max_speed;
    logic       override;
    logic       speed_valid;
    logic [1:0] speed_index;
  } aifs_cmd_s;
endpackage

//--- core/aifs_debounce.sv
// Three-stage synchroniser and settle filter for one contact input
`timescale 1ns/10ps
module aifs_debounce #(
  parameter int unsigned SETTLE_CYCLES = 250000
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic raw_i,
  output logic      level_o,
  output logic      change_o
);
  logic        sync1_ff;
  logic        sync2_ff;
  logic        sync3_ff;
  logic        level_ff;
  logic        change_ff;
  logic [31:0] cnt_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= raw_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Accept a new level only after it has held for the settle time
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      level_ff  <= 1'b0;
      change_ff <= 1'b0;
      cnt_ff    <= 32'h0;
    end
    else
    begin
      change_ff <= 1'b0;
      if (sync2_ff != sync3_ff || sync3_ff == level_ff)
        cnt_ff <= 32'h0;
      else if (cnt_ff >= SETTLE_CYCLES - 1)
      begin
        level_ff  <= sync3_ff;
        change_ff <= 1'b1;
        cnt_ff    <= 32'h0;
      end
      else
        cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign level_o  = level_ff;
  assign change_o = change_ff;
endmodule

//--- core/aifs_select.sv
// Function selector for two programmable dry-contact auxiliary inputs
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "aifs_params.svh"
// Behaviour
// - Code 0 runs the motor while the contact is closed and stops it while open.
// - Code 1 runs the motor while the contact is open and stops it while closed.
// - Code 2 requests run permanently, whatever the contact does.
// - Code 3 stops and latches a fault when the contact opens, cleared only by enter.
// - Code 4 ramps down for thirty seconds plus the hold delay on each change, then reverses.
// - In reversal mode an open contact means forward, a closed one reverse.
// - Code 5 stops and latches a fault when the contact closes, cleared only by enter.
// - Code 6 picks a programmed speed from the combined states of both inputs.
// - Code 7 with a closed contact runs at maximum speed forward, ignoring protections.
// - Code 8 with a closed contact runs at maximum speed reverse, ignoring protections.
// - While an override is active all other run and stop requests are ignored.
// - System configurations 2, 3, 5 and 6 force both selections to code 9.
module aifs_select
  import aifs_pkg::*;
#(
  parameter int unsigned REV_PAUSE_CYCLES = `AIFS_REV_PAUSE_S * `AIFS_CLK_HZ,
  parameter int unsigned HOLD_UNIT_CYCLES = `AIFS_CLK_HZ,
  parameter int unsigned SETTLE_CYCLES    = `AIFS_DEBOUNCE_US * (`AIFS_CLK_HZ / 1000000)
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        aux_input_three_i,
  input  wire logic        aux_input_four_i,
  input  wire logic        enter_key_i,
  input  wire logic        keypad_run_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output aifs_pkg::aifs_cmd_s cmd_o,
  output logic             fault_o
);
  import aifs_pkg::*;

  // Registers written by software
  logic [3:0]  sel_three_ff;
  logic [3:0]  sel_four_ff;
  logic [3:0]  sys_cfg_ff;
  logic [15:0] hold_secs_ff;

  // Bus slave state
  logic [31:0] readdata_ff;
  logic        ack_ff;
  logic [31:0] status_word;

  // Latched faults, reversal sequencer and the registered command
  logic        fault_three_ff;
  logic        fault_four_ff;
  logic        dir_ff;
  logic        dir_target_ff;
  aifs_rev_e   rev_state_ff;
  logic [31:0] rev_cnt_ff;
  logic [15:0] hold_left_ff;
  aifs_cmd_s   cmd_ff;

  // Settled contact levels and one-cycle change pulses
  logic        lvl_three;
  logic        lvl_four;
  logic        chg_three;
  logic        chg_four;

  // Decoded selections and the next command
  logic        special_cfg;
  logic [3:0]  eff_three;
  logic [3:0]  eff_four;
  logic        ovr_fwd;
  logic        ovr_rev;
  logic        rev_mode;
  logic        rev_change;
  logic        rev_lvl;
  logic        pausing;
  logic        run_req;
  aifs_cmd_s   nxt_cmd;

  // Contact closed to the return terminal reads as one
  aifs_debounce #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_deb_three (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .raw_i    (aux_input_three_i),
    .level_o  (lvl_three),
    .change_o (chg_three)
  );

  // Second contact uses an identical filter
  aifs_debounce #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_deb_four (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .raw_i    (aux_input_four_i),
    .level_o  (lvl_four),
    .change_o (chg_four)
  );

  // Run request contributed by one input under its selection code
  function automatic logic run_vote(input logic [3:0] sel, input logic lvl,
                                    input logic flt);
    logic v;
    v = 1'b1;
    unique case (sel)
      `AIFS_SEL_RUN_CLOSED:   v = lvl;
      `AIFS_SEL_RUN_OPEN:     v = !lvl;
      `AIFS_SEL_ALWAYS_RUN:   v = 1'b1;
      `AIFS_SEL_LATCH_OPEN:   v = !flt;
      `AIFS_SEL_LATCH_CLOSED: v = !flt;
      // Codes 4 and 6 to 9 never gate the run request
      default:                v = 1'b1;
    endcase
    return v;
  endfunction

  // Settled edge toward the trip level of a latching code
  function automatic logic latch_trip(input logic [3:0] sel, input logic chg,
                                      input logic lvl);
    logic t;
    t = 1'b0;
    if (sel == `AIFS_SEL_LATCH_OPEN)
      t = chg && !lvl;
    else if (sel == `AIFS_SEL_LATCH_CLOSED)
      t = chg && lvl;
    return t;
  endfunction

  // Configurations with a special function take both inputs over
  assign special_cfg = (sys_cfg_ff == `AIFS_CFG_SPEC_A) || (sys_cfg_ff == `AIFS_CFG_SPEC_B) ||
                       (sys_cfg_ff == `AIFS_CFG_SPEC_C) || (sys_cfg_ff == `AIFS_CFG_SPEC_D);
  // Software reads the forced code back, so it can see the takeover
  assign eff_three = special_cfg ? `AIFS_SEL_SPECIAL : sel_three_ff;
  assign eff_four  = special_cfg ? `AIFS_SEL_SPECIAL : sel_four_ff;

  // Override decode; forward wins if both inputs ask at once
  // Settled levels only, so contact bounce cannot flick the override on
  assign ovr_fwd = (eff_three == `AIFS_SEL_OVR_FWD && lvl_three) ||
                   (eff_four == `AIFS_SEL_OVR_FWD && lvl_four);
  assign ovr_rev = (eff_three == `AIFS_SEL_OVR_REV && lvl_three) ||
                   (eff_four == `AIFS_SEL_OVR_REV && lvl_four);

  // Reversal decode; with both inputs in this mode input three steers the direction
  assign rev_mode   = (eff_three == `AIFS_SEL_REVERSAL) || (eff_four == `AIFS_SEL_REVERSAL);
  assign rev_change = (eff_three == `AIFS_SEL_REVERSAL && chg_three) ||
                      (eff_four == `AIFS_SEL_REVERSAL && chg_four);
  assign rev_lvl    = (eff_three == `AIFS_SEL_REVERSAL) ? lvl_three : lvl_four;
  assign pausing    = (rev_state_ff != AIFS_IDLE);

  // Latching faults; the set beats a simultaneous enter press
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fault_three_ff <= 1'b0;
      fault_four_ff  <= 1'b0;
    end
    else
    begin
      if (latch_trip(eff_three, chg_three, lvl_three))
        fault_three_ff <= 1'b1;
      else if (enter_key_i)
        fault_three_ff <= 1'b0;
      if (latch_trip(eff_four, chg_four, lvl_four))
        fault_four_ff <= 1'b1;
      else if (enter_key_i)
        fault_four_ff <= 1'b0;
    end
  end

  // Reversal sequencer: pause, extra hold, then run the new direction
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rev_state_ff  <= AIFS_IDLE;
      rev_cnt_ff    <= 32'h0;
      hold_left_ff  <= 16'h0;
      dir_ff        <= 1'b0;
      dir_target_ff <= 1'b0;
    end
    else if (!rev_mode)
    begin
      rev_state_ff <= AIFS_IDLE;
      dir_ff       <= 1'b0;
    end
    else
    begin
      // A change during the pause restarts the whole wait
      if (rev_change)
      begin
        rev_state_ff  <= AIFS_PAUSE;
        rev_cnt_ff    <= 32'h0;
        hold_left_ff  <= hold_secs_ff;
        dir_target_ff <= rev_lvl;
      end
      else
      begin
        unique case (rev_state_ff)
          // Idle tracks the contact, so entering the mode needs no pause
          AIFS_IDLE:
            dir_ff <= rev_lvl;
          // Thirty-second ramp-down comes first
          AIFS_PAUSE:
            if (rev_cnt_ff >= REV_PAUSE_CYCLES - 1)
            begin
              rev_cnt_ff   <= 32'h0;
              rev_state_ff <= AIFS_HOLD;
            end
            else
              rev_cnt_ff <= rev_cnt_ff + 32'h1;
          // Then one hold unit for each programmed second
          AIFS_HOLD:
            if (hold_left_ff == 16'h0)
            begin
              dir_ff       <= dir_target_ff;
              rev_state_ff <= AIFS_IDLE;
            end
            else if (rev_cnt_ff >= HOLD_UNIT_CYCLES - 1)
            begin
              rev_cnt_ff   <= 32'h0;
              hold_left_ff <= hold_left_ff - 16'h1;
            end
            else
              rev_cnt_ff <= rev_cnt_ff + 32'h1;
          default:
            rev_state_ff <= AIFS_IDLE;
        endcase
      end
    end
  end

  // Command decode: overrides take priority over everything else
  always_comb
  begin
    // A reversal pause is a stop even while the keypad asks to run
    run_req = keypad_run_i && run_vote(eff_three, lvl_three, fault_three_ff) &&
              run_vote(eff_four, lvl_four, fault_four_ff) && !pausing;
    nxt_cmd = '0;
    if (ovr_fwd || ovr_rev)
    begin
      nxt_cmd.run       = 1'b1;
      nxt_cmd.override  = 1'b1;
      nxt_cmd.max_speed = 1'b1;
      nxt_cmd.reverse   = !ovr_fwd;
    end
    else
    begin
      nxt_cmd.run     = run_req;
      nxt_cmd.reverse = rev_mode && dir_ff;
      // Only the index leaves here; the speed table lookup is downstream
      if (eff_three == `AIFS_SEL_SPEED || eff_four == `AIFS_SEL_SPEED)
      begin
        nxt_cmd.speed_valid = 1'b1;
        nxt_cmd.speed_index = {lvl_four, lvl_three};
      end
    end
  end

  // Registered command, so the drive never sees decode glitches
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cmd_ff <= '0;
    else
      cmd_ff <= nxt_cmd;
  end

  // Avalon slave: one wait cycle, then acknowledge
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;

  // Acknowledge alternates, so a held request is answered every second cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
  end

  // Register writes land on the acknowledge edge only
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sel_three_ff <= `AIFS_SEL_RESET_THREE;
      sel_four_ff  <= `AIFS_SEL_RESET_FOUR;
      sys_cfg_ff   <= 4'h0;
      hold_secs_ff <= 16'h0;
    end
    // Codes above 9 are stored as written but decode as always-run
    else if (avs_write_i && ack_ff)
    begin
      unique case (avs_address_i)
        `AIFS_ADDR_SEL:
          if (avs_byteenable_i[0])
          begin
            sel_three_ff <= avs_writedata_i[3:0];
            sel_four_ff  <= avs_writedata_i[7:4];
          end
        `AIFS_ADDR_CFG:
          if (avs_byteenable_i[0])
            sys_cfg_ff <= avs_writedata_i[3:0];
        `AIFS_ADDR_HOLD:
        begin
          if (avs_byteenable_i[0])
            hold_secs_ff[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1])
            hold_secs_ff[15:8] <= avs_writedata_i[15:8];
        end
        default:
          ;
      endcase
    end
  end

  // Status word: levels, faults, direction and sequencer state
  assign status_word = {24'h0, rev_state_ff, dir_ff, fault_four_ff, fault_three_ff,
                        lvl_four, lvl_three};

  // Read data is registered and valid on the acknowledge edge
  // Reads have no side effects, so a repeated read is harmless
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      readdata_ff <= 32'h0;
    else if (avs_read_i && !ack_ff)
    begin
      unique case (avs_address_i)
        `AIFS_ADDR_SEL:    readdata_ff <= {24'h0, eff_four, eff_three};
        `AIFS_ADDR_CFG:    readdata_ff <= {28'h0, sys_cfg_ff};
        `AIFS_ADDR_HOLD:   readdata_ff <= {16'h0, hold_secs_ff};
        `AIFS_ADDR_STATUS: readdata_ff <= status_word;
        default:           readdata_ff <= 32'h0;
      endcase
    end
  end

  assign avs_readdata_o = readdata_ff;
  assign cmd_o          = cmd_ff;
  assign fault_o        = fault_three_ff || fault_four_ff;
endmodule

//--- test/aifs_select_chk.sv
// Port checker for the auxiliary input selector, bound to its top
`timescale 1ns/10ps
module aifs_select_chk
  import aifs_pkg::*;
#(
  parameter int unsigned REV_PAUSE_CYCLES = 20
) (
  input wire logic                clk_i,
  input wire logic                reset_i,
  input wire logic                keypad_run_i,
  input wire logic                enter_key_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic                avs_waitrequest_o,
  input wire aifs_pkg::aifs_cmd_s cmd_o,
  input wire logic                fault_o
);
  int unsigned stop_cnt_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Length of the current stop, so a direction flip can be timed
  always_ff @(posedge clk_i)
    if (reset_i || cmd_o.run)
      stop_cnt_ff <= 0;
    else
      stop_cnt_ff <= stop_cnt_ff + 1;
  sequence s_kp_low;
    !keypad_run_i ##1 !keypad_run_i;
  endsequence
  // Override hands reverse back without a pause, so it is left out
  sequence s_flip;
    $changed(cmd_o.reverse) && !cmd_o.override && !$past(cmd_o.override);
  endsequence
  property p_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  property p_idle; !avs_read_i && !avs_write_i |-> !avs_waitrequest_o; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_ovr; cmd_o.override |-> cmd_o.run && cmd_o.max_speed; endproperty
  a_ovr: assert property (p_ovr) else $error("override not at full speed");
  property p_ovr_kp; $fell(keypad_run_i) && cmd_o.override |=> cmd_o.run; endproperty
  a_ovr_kp: assert property (p_ovr_kp) else $error("override obeyed keypad");
  property p_gate; s_kp_low ##0 !cmd_o.override |-> !cmd_o.run; endproperty
  a_gate: assert property (p_gate) else $error("run without keypad");
  property p_hold; fault_o && !enter_key_i |=> fault_o; endproperty
  a_hold: assert property (p_hold) else $error("fault lost without enter");
  property p_clr; $fell(fault_o) |-> $past(enter_key_i); endproperty
  a_clr: assert property (p_clr) else $error("fault cleared by other cause");
  property p_stop; fault_o [*2] ##0 !cmd_o.override |-> !cmd_o.run; endproperty
  a_stop: assert property (p_stop) else $error("running with fault");
  property p_rev; s_flip |-> stop_cnt_ff >= REV_PAUSE_CYCLES; endproperty
  a_rev: assert property (p_rev) else $error("direction flip too soon");
endmodule
bind aifs_select aifs_select_chk #(.REV_PAUSE_CYCLES(REV_PAUSE_CYCLES)) aifs_select_chk_i (
  .clk_i(clk_i), .reset_i(reset_i), .keypad_run_i(keypad_run_i), .enter_key_i(enter_key_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .cmd_o(cmd_o), .fault_o(fault_o));

//--- test/aifs_contacts.sv
// Bouncing dry-contact pair standing at the selector inputs
`timescale 1ns/10ps
module aifs_contacts #(
  parameter int unsigned BOUNCE = 2
) (
  input  wire logic clk_i,
  input  wire logic close_three_i,
  input  wire logic close_four_i,
  output logic      aux_input_three_o,
  output logic      aux_input_four_o
);
  logic [1:0]  want;
  logic [1:0]  lvl  = 2'h0;
  logic [1:0]  prev = 2'h0;
  int unsigned bnc [2] = '{0, 0};
  assign want = {close_four_i, close_three_i};
  assign {aux_input_four_o, aux_input_three_o} = lvl;
  // Each change chatters for fewer cycles than the settle window
  always @(posedge clk_i)
    for (int k = 0; k < 2; k++)
      if (want[k] != prev[k])
      begin
        prev[k] <= want[k];
        bnc[k]  <= BOUNCE;
        lvl[k]  <= !lvl[k];
      end
      else if (bnc[k] != 0)
      begin
        bnc[k] <= bnc[k] - 1;
        lvl[k] <= (bnc[k] == 1) ? want[k] : !lvl[k];
      end
endmodule

//--- test/tb.sv
// Self-checking bench for the auxiliary input selector
`timescale 1ns/10ps
`include "aifs_params.svh"
module tb;
  import aifs_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        c3 = 1'b0;
  logic        c4 = 1'b0;
  logic        enter_key_i = 1'b0;
  logic        keypad_run_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        pin_three;
  logic        pin_four;
  aifs_cmd_s   cmd_o;
  logic        fault_o;
  int          err_total = 0;
  int          cmp_count = 0;
  always #20 clk_i = !clk_i;
  aifs_contacts aifs_contacts_i (.clk_i(clk_i), .close_three_i(c3), .close_four_i(c4),
    .aux_input_three_o(pin_three), .aux_input_four_o(pin_four));
  aifs_select #(.REV_PAUSE_CYCLES(20), .HOLD_UNIT_CYCLES(5), .SETTLE_CYCLES(4)) aifs_select_i (
    .clk_i(clk_i), .reset_i(reset_i), .aux_input_three_i(pin_three), .aux_input_four_i(pin_four),
    .enter_key_i(enter_key_i), .keypad_run_i(keypad_run_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .cmd_o(cmd_o), .fault_o(fault_o));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the request until waitrequest is seen low, then spends one idle edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // No limit of its own: only the watchdog ends a wait with no answer
    do
    begin
      @(posedge clk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, `AIFS_ADDR_SEL, 32'h0, q);
    chk("sel", q, {24'h0, `AIFS_SEL_RESET_FOUR, `AIFS_SEL_RESET_THREE});
    bus(1'b1, `AIFS_ADDR_HOLD, 32'h1, q);
    bus(1'b0, `AIFS_ADDR_HOLD, 32'h0, q);
    chk("hold", q, 32'h1);
    bus(1'b1, 4'h1, 32'hFF, q);
    bus(1'b0, 4'h1, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask
  // Input four always votes run, so input three alone decides
  task automatic t_run();
    logic [31:0] q;
    keypad_run_i <= 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      bus(1'b1, `AIFS_ADDR_SEL, 32'h20 | 32'(c), q);
      for (int s = 0; s < 2; s++)
      begin
        c3 <= s[0];
        wt(16);
        chk("run", cmd_o.run, (c == 0) ? s[0] : (c == 1) ? !s[0] : 1'b1);
      end
    end
    $display("t_run done");
  endtask
  // Trip level is open for the first code and closed for the second
  task automatic t_latch();
    logic [31:0] q;
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, `AIFS_ADDR_SEL, k ? 32'h25 : 32'h23, q);
      c3 <= !k[0];
      wt(16);
      c3 <= k[0];
      wt(16);
      chk("trip", {fault_o, cmd_o.run}, 2'b10);
      bus(1'b0, `AIFS_ADDR_STATUS, 32'h0, q);
      chk("status", q, 32'h24 | 32'(k));
      c3 <= !k[0];
      wt(16);
      chk("stay", {fault_o, cmd_o.run}, 2'b10);
      enter_key_i <= 1'b1;
      wt(2);
      enter_key_i <= 1'b0;
      wt(2);
      chk("clear", {fault_o, cmd_o.run}, 2'b01);
    end
    $display("t_latch done");
  endtask
  task automatic t_speed();
    logic [31:0] q;
    bus(1'b1, `AIFS_ADDR_SEL, 32'h66, q);
    for (int i = 0; i < 4; i++)
    begin
      c3 <= i[0];
      c4 <= i[1];
      wt(16);
      chk("speed", {cmd_o.speed_valid, cmd_o.speed_index}, {1'b1, i[1:0]});
    end
    $display("t_speed done");
  endtask
  // Keypad is dropped and pulsed while the override holds the motor on
  task automatic t_ovr();
    logic [31:0] q;
    keypad_run_i <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      c3 <= 1'b0;
      bus(1'b1, `AIFS_ADDR_SEL, k ? 32'h28 : 32'h27, q);
      wt(16);
      chk("idle", {cmd_o.run, cmd_o.override}, 2'b00);
      c3 <= 1'b1;
      wt(16);
      keypad_run_i <= 1'b1;
      wt(2);
      keypad_run_i <= 1'b0;
      wt(2);
      chk("ovr", cmd_o[6:3], {1'b1, k[0], 2'b11});
    end
    c3 <= 1'b0;
    keypad_run_i <= 1'b1;
    // Let the contact settle open so reversal mode starts without a flip
    wt(16);
    $display("t_ovr done");
  endtask
  // Pause is 20 cycles plus one hold unit of 5
  task automatic t_rev();
    logic [31:0] q;
    int n;
    bus(1'b1, `AIFS_ADDR_SEL, 32'h24, q);
    wt(16);
    chk("fwd", {cmd_o.run, cmd_o.reverse}, 2'b10);
    for (int k = 1; k >= 0; k--)
    begin
      c3 <= k[0];
      n = 0;
      while (cmd_o.run !== 1'b0 && n < 40)
      begin
        @(posedge clk_i);
        n++;
      end
      chk("stop", cmd_o.run, 1'b0);
      n = 0;
      while (cmd_o.run !== 1'b1 && n < 200)
      begin
        @(posedge clk_i);
        n++;
      end
      chk("pause", n >= 25 && n < 40, 1'b1);
      chk("dir", cmd_o.reverse, k[0]);
    end
    $display("t_rev done");
  endtask
  task automatic t_cfg();
    logic [31:0] q;
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, `AIFS_ADDR_CFG, 32'(c), q);
      bus(1'b0, `AIFS_ADDR_SEL, 32'h0, q);
      chk("forced", q, (c inside {2, 3, 5, 6}) ? 32'h99 : 32'h24);
    end
    $display("t_cfg done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_run();
    t_latch();
    t_speed();
    t_ovr();
    t_rev();
    t_cfg();
    report_and_stop();
  end
  // Whole run needs about 550 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule
